// *** design/drec_pkg.sv ***
// Package for the debug request entry control block.
// Assumes a single core clock domain; all pins arrive asynchronously.
`default_nettype none
package drec_pkg;
    localparam int unsigned CORE_CLK_MHZ = 50;
    localparam int unsigned WORD_W       = 8;
    localparam int unsigned ACK_CYCLES   = 4;
    localparam int unsigned ACK_CNT_W    = 3;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam logic [ACK_CNT_W-1:0] ACK_LAST = ACK_CNT_W'(ACK_CYCLES - 1);
    localparam logic [ACK_CNT_W-1:0] ACK_ZERO = 3'h0;
    localparam logic SOUT_IDLE = 1'b1;
    localparam logic SOUT_ACK  = 1'b0;

    typedef enum logic [4:0] {
        S_RUN  = 5'b0_0001,
        S_WAIT = 5'b0_0010,
        S_ACK  = 5'b0_0100,
        S_REL  = 5'b0_1000,
        S_DBG  = 5'b1_0000
    } drec_state_e;

    typedef struct packed {
        logic req_n;
        logic sclk;
        logic sin;
    } drec_pins_s;

    // Idle pin levels: request pulled up, serial clock and data pulled down
    localparam drec_pins_s PINS_IDLE = '{req_n: 1'b1, sclk: 1'b0, sin: 1'b0};
endpackage : drec_pkg
`default_nettype wire

// *** design/drec_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the inputs are steady for at least two core clock periods.
`default_nettype none
module drec_sync #(
    parameter int unsigned W       = 3,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Pins in, synchronised out
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

    a_sync_two_flop: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(rstn, 2) |-> sync_o == $past(async_i, 2))
        else $error("Synchroniser latency is not two cycles");
endmodule : drec_sync
`default_nettype wire

// *** design/drec_entry.sv ***
// Debug request entry control: enters debug mode, acknowledges on the
// serial output, resets the command controller and shifts serial words.
// Assumes the core reports instruction completion and low-power state.
`default_nettype none
module drec_entry
    import drec_pkg::*;
#(
    parameter int unsigned W = drec_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Debug pins
    input  wire logic         debug_request_n,
    input  wire logic         debug_serial_clock,
    input  wire logic         debug_serial_in,
    output var  logic         debug_serial_out,
    // Core status
    input  wire logic         instr_done,
    input  wire logic         low_power,
    input  wire logic         debug_exit,
    // Core control
    output var  logic         save_pipeline,
    output var  logic         debug_halt,
    output var  logic         debug_mode,
    output var  logic         cmd_ctrl_reset,
    // Command words
    output var  logic         cmd_valid,
    output var  logic [W-1:0] cmd_word,
    input  wire logic         tx_load,
    input  wire logic [W-1:0] tx_word
);
    import drec_pkg::*;

    localparam int unsigned CNT_W = $clog2(W);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(W - 1);
    localparam logic [CNT_W-1:0] BIT_ZERO = '0;

    drec_pins_s  pins_a;
    drec_pins_s  pins_s;
    drec_state_e state_q, state_d;
    logic [ACK_CNT_W-1:0] ack_cnt_q, ack_cnt_d;
    logic         sclk_q, sclk_d;
    logic         sclk_fall, sclk_rise;
    logic [W-1:0] rx_q, rx_d;
    logic [CNT_W-1:0] bit_q, bit_d;
    logic [W-1:0] tx_q, tx_d;
    logic         sout_q, sout_d;
    logic         save_q, save_d;
    logic         halt_q, halt_d;
    logic         mode_q, mode_d;
    logic         crst_q, crst_d;
    logic         cval_q, cval_d;
    logic [W-1:0] cword_q, cword_d;

    assign pins_a = '{req_n: debug_request_n, sclk: debug_serial_clock,
                      sin: debug_serial_in};

    // Reset to idle pin levels so no false serial clock edge follows reset
    drec_sync #(.W($bits(drec_pins_s)), .RST_VAL(PINS_IDLE)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_i  (pins_a),
        .sync_o   (pins_s)
    );

    assign sclk_fall = sclk_q & ~pins_s.sclk;
    assign sclk_rise = ~sclk_q & pins_s.sclk;

    // Entry state machine
    always_comb begin
        state_d   = state_q;
        ack_cnt_d = ACK_ZERO;
        save_d    = 1'b0;
        crst_d    = 1'b0;
        unique case (state_q)
            S_RUN: begin
                if (!pins_s.req_n && low_power) begin
                    state_d = S_ACK;
                    save_d  = 1'b1;
                end else if (!pins_s.req_n) begin
                    state_d = S_WAIT;
                end
            end
            S_WAIT: begin
                if (instr_done) begin
                    state_d = S_ACK;
                    save_d  = 1'b1;
                end
            end
            S_ACK: begin
                ack_cnt_d = ack_cnt_q + 1'b1;
                if (ack_cnt_q == ACK_LAST) begin
                    state_d   = S_REL;
                    ack_cnt_d = ACK_ZERO;
                end
            end
            S_REL: begin
                if (pins_s.req_n) begin
                    state_d = S_DBG;
                end
            end
            S_DBG: begin
                if (!pins_s.req_n) begin
                    state_d = S_ACK;
                    crst_d  = 1'b1;
                end else if (debug_exit) begin
                    state_d = S_RUN;
                end
            end
        endcase
        halt_d = (state_d != S_RUN) && (state_d != S_WAIT);
        mode_d = (state_d == S_DBG);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= S_RUN;
            ack_cnt_q <= ACK_ZERO;
            save_q    <= 1'b0;
            crst_q    <= 1'b0;
            halt_q    <= 1'b0;
            mode_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            ack_cnt_q <= ack_cnt_d;
            save_q    <= save_d;
            crst_q    <= crst_d;
            halt_q    <= halt_d;
            mode_q    <= mode_d;
        end
    end

    // Serial shifting, only while idle in debug mode
    always_comb begin
        sclk_d  = pins_s.sclk;
        rx_d    = rx_q;
        bit_d   = bit_q;
        tx_d    = tx_q;
        cval_d  = 1'b0;
        cword_d = cword_q;
        if (state_q != S_DBG) begin
            bit_d = BIT_ZERO;
            tx_d  = '1;
        end else begin
            if (sclk_fall) begin
                rx_d  = {rx_q[W-2:0], pins_s.sin};
                bit_d = bit_q + 1'b1;
                if (bit_q == BIT_LAST) begin
                    bit_d   = BIT_ZERO;
                    cval_d  = 1'b1;
                    cword_d = {rx_q[W-2:0], pins_s.sin};
                end
            end
            if (tx_load) begin
                tx_d = tx_word;
            end else if (sclk_rise) begin
                tx_d = {tx_q[W-2:0], SOUT_IDLE};
            end
        end
        sout_d = (state_q == S_ACK) ? SOUT_ACK : tx_q[W-1];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q  <= 1'b0;
            rx_q    <= '0;
            bit_q   <= BIT_ZERO;
            tx_q    <= '1;
            cval_q  <= 1'b0;
            cword_q <= '0;
            sout_q  <= SOUT_IDLE;
        end else begin
            sclk_q  <= sclk_d;
            rx_q    <= rx_d;
            bit_q   <= bit_d;
            tx_q    <= tx_d;
            cval_q  <= cval_d;
            cword_q <= cword_d;
            sout_q  <= sout_d;
        end
    end

    assign debug_serial_out = sout_q;
    assign save_pipeline    = save_q;
    assign debug_halt       = halt_q;
    assign debug_mode       = mode_q;
    assign cmd_ctrl_reset   = crst_q;
    assign cmd_valid        = cval_q;
    assign cmd_word         = cword_q;

    // Checks
    a_run_to_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_RUN && !pins_s.req_n && !low_power |=> state_q == S_WAIT ##0 !debug_halt
    ) else $error("Request did not wait for instruction end");
    a_save_on_done: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_WAIT && instr_done |=> save_pipeline && state_q == S_ACK
    ) else $error("Pipeline not saved at instruction end");
    a_debug_halts: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_DBG && !debug_exit |=> debug_halt
    ) else $error("Core not halted in debug mode");
    a_lowpower_entry: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_RUN && !pins_s.req_n && low_power |=> state_q == S_ACK ##0 save_pipeline
    ) else $error("Low-power request did not acknowledge");
    a_ack_pulse_len: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(state_q == S_ACK) |=> !debug_serial_out [*4] ##1 debug_serial_out
    ) else $error("Acknowledge pulse wrong length");
    a_ctrl_reset: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_DBG && !pins_s.req_n |=> cmd_ctrl_reset && state_q == S_ACK
    ) else $error("Controller reset handshake missing");
    a_hold_release: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_REL && !pins_s.req_n |=> state_q == S_REL && !cmd_valid
    ) else $error("Left release wait while request held");
    a_rx_on_fall: assert property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_DBG && !sclk_fall |=> $stable(bit_q)
    ) else $error("Input shifted without falling edge");
    a_rx_msb_first: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(cmd_valid) |-> cmd_word[0] == $past(pins_s.sin)
    ) else $error("Last bit received is not least significant");

    c_lowpower: cover property (@(posedge core_clk) disable iff (!rstn)
        state_q == S_RUN && !pins_s.req_n && low_power);
    c_ctrl_reset: cover property (@(posedge core_clk) disable iff (!rstn) cmd_ctrl_reset);
    c_cmd_word: cover property (@(posedge core_clk) disable iff (!rstn) cmd_valid);
endmodule : drec_entry
`default_nettype wire

// *** verif/drec_host_model.sv ***
// Model of the external debug command controller at the debug pins.
// Assumes a 50 MHz core clock; pins change just after its rising edge.
`default_nettype none
module drec_host_model (
    // Clock
    input  wire logic core_clk,
    // Debug pins
    input  wire logic debug_serial_out,
    output var  logic debug_request_n,
    output var  logic debug_serial_clock,
    output var  logic debug_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        debug_request_n    = 1'b1;
        debug_serial_clock = 1'b0;
        debug_serial_in    = 1'b0;
    end

    // Drive or release the request pin
    task automatic req(input logic lvl);
        @(posedge core_clk);
        debug_request_n <= lvl;
    endtask : req

    // Keep request low until the acknowledge ends; return its length
    task automatic wait_ack(output int len);
        int t;
        t   = 0;
        len = 0;
        while (debug_serial_out !== 1'b0 && t < 200) begin
            @(negedge core_clk);
            t++;
        end
        while (debug_serial_out === 1'b0 && len < 50) begin
            @(negedge core_clk);
            len++;
        end
    endtask : wait_ack

    // One word each way; period of eight core clocks
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(negedge core_clk);
            rx[i] = debug_serial_out;
            @(posedge core_clk);
            debug_serial_clock <= 1'b1;
            debug_serial_in    <= tx[i];
            repeat (4) @(posedge core_clk);
            debug_serial_clock <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
        @(posedge core_clk);
        debug_serial_in <= 1'b0;
    endtask : xfer
endmodule : drec_host_model
`default_nettype wire

// *** verif/drec_entry_test.sv ***
// Self-checking testbench for the debug request entry control block.
// Assumes the host model drives the debug pins; core status comes from here.
`default_nettype none
module drec_entry_test;
    timeunit 1ns;
    timeprecision 1ps;
    import drec_pkg::*;

    logic core_clk, rstn, instr_done, low_power, debug_exit, tx_load;
    logic [7:0] tx_word, cmd_word, last_word, rx;
    logic req_n, sclk, sin, sout, save_pipeline, debug_halt, debug_mode;
    logic cmd_ctrl_reset, cmd_valid;
    int n_fail, n_checks, n_save, n_rst, n_cmd, cyc, len;

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    drec_host_model u_drec_host_model (.core_clk(core_clk), .debug_serial_out(sout),
        .debug_request_n(req_n), .debug_serial_clock(sclk), .debug_serial_in(sin));

    drec_entry #(.W(WORD_W)) u_drec_entry (.core_clk(core_clk), .rstn(rstn),
        .debug_request_n(req_n), .debug_serial_clock(sclk), .debug_serial_in(sin),
        .debug_serial_out(sout), .instr_done(instr_done), .low_power(low_power),
        .debug_exit(debug_exit), .save_pipeline(save_pipeline), .debug_halt(debug_halt),
        .debug_mode(debug_mode), .cmd_ctrl_reset(cmd_ctrl_reset), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .tx_load(tx_load), .tx_word(tx_word));

    // Pulse counters
    always @(posedge core_clk) begin
        if (save_pipeline === 1'b1) n_save <= n_save + 1;
        if (cmd_ctrl_reset === 1'b1) n_rst <= n_rst + 1;
        if (cmd_valid === 1'b1) begin
            n_cmd     <= n_cmd + 1;
            last_word <= cmd_word;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic clear();
        @(negedge core_clk);
        n_save = 0;
        n_rst  = 0;
        n_cmd  = 0;
    endtask : clear

    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : settle

    task automatic entry_run();
        clear();
        u_drec_host_model.req(1'b0);
        settle(8);
        check("serial out before done", sout, 1'b1);
        check("halt before done", debug_halt, 1'b0);
        @(posedge core_clk) instr_done <= 1'b1;
        @(posedge core_clk) instr_done <= 1'b0;
        u_drec_host_model.wait_ack(len);
        check("ack length", len, 4);
        check("pipeline saves", n_save, 1);
        check("halt in ack", debug_halt, 1'b1);
        u_drec_host_model.req(1'b1);
        settle(6);
        check("debug mode", debug_mode, 1'b1);
    endtask : entry_run

    task automatic serial_word();
        clear();
        @(posedge core_clk) tx_load <= 1'b1;
        tx_word <= 8'h1E;
        @(posedge core_clk) tx_load <= 1'b0;
        settle(2);
        check("first bit out", sout, 1'b0);
        u_drec_host_model.xfer(8'hB4, rx);
        settle(6);
        check("words received", n_cmd, 1);
        check("command word", last_word, 8'hB4);
        check("word sent", rx, 8'h1E);
        check("still halted", debug_halt, 1'b1);
    endtask : serial_word

    task automatic ctrl_reset();
        clear();
        u_drec_host_model.req(1'b0);
        u_drec_host_model.wait_ack(len);
        check("reset ack length", len, 4);
        check("controller resets", n_rst, 1);
        check("no save on reset", n_save, 0);
        u_drec_host_model.req(1'b1);
        settle(6);
        check("back in debug", debug_mode, 1'b1);
    endtask : ctrl_reset

    task automatic low_power_entry();
        @(posedge core_clk) debug_exit <= 1'b1;
        @(posedge core_clk) debug_exit <= 1'b0;
        settle(3);
        check("left debug", debug_mode, 1'b0);
        check("running", debug_halt, 1'b0);
        clear();
        @(posedge core_clk) low_power <= 1'b1;
        u_drec_host_model.req(1'b0);
        u_drec_host_model.wait_ack(len);
        check("sleep ack length", len, 4);
        check("sleep save", n_save, 1);
        @(posedge core_clk) low_power <= 1'b0;
        u_drec_host_model.req(1'b1);
        settle(6);
        check("debug from sleep", debug_mode, 1'b1);
    endtask : low_power_entry

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    initial begin
        rstn       = 1'b0;
        instr_done = 1'b0;
        low_power  = 1'b0;
        debug_exit = 1'b0;
        tx_load    = 1'b0;
        tx_word    = 8'h00;
        last_word  = 8'h00;
        n_fail     = 0;
        n_checks   = 0;
        cyc        = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        settle(3);
        entry_run();
        serial_word();
        ctrl_reset();
        low_power_entry();
        close_out();
    end
endmodule : drec_entry_test
`default_nettype wire
